// ==== src/rca_regs.svh ====
`ifndef RCA_REGS_SVH
`define RCA_REGS_SVH

// ============================================================
// timing
`define RCA_OSC_IN_MHZ 20
`define RCA_INSTR_CYCLE_NS 200
`define RCA_PHASES ((`RCA_INSTR_CYCLE_NS * `RCA_OSC_IN_MHZ) / 1000)

// ============================================================
// special function registers, mirrored in both banks
`define RCA_SFR_INDIRECT 7'h00
`define RCA_SFR_PCL 7'h02
`define RCA_SFR_STATUS 7'h03
`define RCA_SFR_FSR 7'h04

// ============================================================
// status bit positions and reset values
`define RCA_ST_C 0
`define RCA_ST_DC 1
`define RCA_ST_Z 2
`define RCA_RESET_VECTOR 13'h0000
`define RCA_NOP 14'h0000

// ============================================================
// instruction groups, word bits 13:12; goto prefix, word bits 13:11
`define RCA_GRP_BYTE 2'h0
`define RCA_GRP_LIT 2'h3
`define RCA_GOTO_PFX 3'h5

// byte oriented codes, word bits 11:8
`define RCA_OP_MOVWF 4'h0
`define RCA_OP_CLRF 4'h1
`define RCA_OP_SUBWF 4'h2
`define RCA_OP_DECF 4'h3
`define RCA_OP_IORWF 4'h4
`define RCA_OP_ANDWF 4'h5
`define RCA_OP_XORWF 4'h6
`define RCA_OP_ADDWF 4'h7
`define RCA_OP_MOVF 4'h8
`define RCA_OP_COMF 4'h9
`define RCA_OP_INCF 4'hA
`define RCA_OP_DECFSZ 4'hB
`define RCA_OP_RRF 4'hC
`define RCA_OP_RLF 4'hD
`define RCA_OP_SWAPF 4'hE
`define RCA_OP_INCFSZ 4'hF

// literal codes, word bits 11:8
`define RCA_LOP_IOR 4'h8
`define RCA_LOP_AND 4'h9
`define RCA_LOP_XOR 4'hA

`endif

// ==== src/rca_pkg.sv ====
package rca_pkg;

    // ============================================================
    // quarter phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } rca_phase_e;

    // ============================================================
    // data bus request
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } rca_dbus_s;

    typedef struct packed {
        logic z;
        logic half_borrow_flag;
        logic c;
    } rca_flags_s;

    // ============================================================
    // whole core state
    typedef struct packed {
        rca_phase_e ph;
        logic [12:0] pc;
        logic [13:0] ir;
        logic [7:0] w;
        rca_flags_s fl;
        logic [7:0] fsr;
        logic [7:0] opnd;
        logic take;
        logic skip;
        logic [12:0] tgt;
        rca_dbus_s dbus;
        logic clkout;
    } rca_state_s;

endpackage

// ==== src/rca_core.sv ====
`timescale 1ns/10ps
`include "rca_regs.svh"

// How it works
// - one 14-bit word fetched per cycle over its own program bus
// - next word is fetched while the current one executes
// - plain instructions take one cycle, branches and skips take two
// - eight bit unit doing add, subtract, rotate and logic
// - add and subtract work on two's complement bytes
// - two-operand ops pair the accumulator with a file byte or literal
// - single-operand ops act on the accumulator or a file byte
// - the accumulator is eight bits and has no data address
// - operations update carry, half borrow and zero as they define
// - on subtract carry and half borrow are inverted borrows
// - program counter, status and pointer sit in data space
// - file bytes reached by direct address or through the pointer
// - every operation works on every file address through the pointer, direct addresses reach bank zero only
// - in resistor-capacitor mode a quarter rate clock goes out
// - holding the reset pin low keeps the core in reset
// - each cycle is four quarter phases from the input clock
// - operand read in phase two, destination written in phase four
module rca_core (
    // clock and master reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // oscillator mode strap
    input wire logic resistor_capacitor_osc_mode_i,
    // program bus
    output logic [12:0] prog_addr_o,
    input wire logic [13:0] prog_data_i,
    // data bus
    output rca_pkg::rca_dbus_s data_req_o,
    input wire logic [7:0] data_rdata_i,
    // status
    output rca_pkg::rca_flags_s flags_o,
    output logic instr_rate_output_o
);

    rca_pkg::rca_state_s st_q;
    rca_pkg::rca_state_s st_d;

    // ============================================================
    // decode and arithmetic
    logic [1:0] grp;
    logic [3:0] op;
    logic dest_f;
    logic [7:0] ea;
    logic sfr_hit;
    logic [7:0] a_op;
    logic [7:0] b_op;
    logic cin;
    logic [4:0] lo;
    logic [4:0] hi;
    logic [7:0] res;
    logic upd_z;
    logic upd_c;
    logic is_sub;
    logic wr_file;
    logic [7:0] rd_val;

    assign grp = st_q.ir[13:12];
    assign op = st_q.ir[11:8];
    assign dest_f = st_q.ir[7];
    // address zero means indirect through the pointer
    assign ea = (st_q.ir[6:0] == `RCA_SFR_INDIRECT) ? st_q.fsr : {1'b0, st_q.ir[6:0]};
    // sfr decode ignores the bank bit, so core registers mirror
    assign sfr_hit = (ea[6:0] == `RCA_SFR_PCL) || (ea[6:0] == `RCA_SFR_STATUS)
        || (ea[6:0] == `RCA_SFR_FSR);

    always_comb begin
        case (ea[6:0])
            `RCA_SFR_PCL: rd_val = st_q.pc[7:0];
            `RCA_SFR_STATUS: rd_val = {5'h00, st_q.fl.z, st_q.fl.half_borrow_flag, st_q.fl.c};
            `RCA_SFR_FSR: rd_val = st_q.fsr;
            default: rd_val = data_rdata_i;
        endcase
    end

    always_comb begin
        a_op = st_q.opnd;
        b_op = st_q.w;
        cin = 1'b0;
        is_sub = 1'b0;
        if ((grp == `RCA_GRP_BYTE && op == `RCA_OP_SUBWF)
            || (grp == `RCA_GRP_LIT && op[3:1] == 3'h6)) begin
            // subtract as operand plus inverted w plus one
            b_op = ~st_q.w;
            cin = 1'b1;
            is_sub = 1'b1;
        end
        lo = {1'b0, a_op[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
        hi = {1'b0, a_op[7:4]} + {1'b0, b_op[7:4]} + {4'h0, lo[4]};
    end

    always_comb begin
        res = st_q.opnd;
        upd_z = 1'b1;
        upd_c = 1'b0;
        wr_file = 1'b0;
        if (grp == `RCA_GRP_BYTE) begin
            wr_file = dest_f;
            case (op)
                `RCA_OP_MOVWF: begin
                    res = st_q.w;
                    upd_z = 1'b0;
                end
                `RCA_OP_CLRF: res = 8'h00;
                `RCA_OP_SUBWF, `RCA_OP_ADDWF: begin
                    res = {hi[3:0], lo[3:0]};
                    upd_c = 1'b1;
                end
                `RCA_OP_DECF, `RCA_OP_DECFSZ: res = st_q.opnd - 8'h01;
                `RCA_OP_INCF, `RCA_OP_INCFSZ: res = st_q.opnd + 8'h01;
                `RCA_OP_IORWF: res = st_q.opnd | st_q.w;
                `RCA_OP_ANDWF: res = st_q.opnd & st_q.w;
                `RCA_OP_XORWF: res = st_q.opnd ^ st_q.w;
                `RCA_OP_COMF: res = ~st_q.opnd;
                `RCA_OP_RRF: res = {st_q.fl.c, st_q.opnd[7:1]};
                `RCA_OP_RLF: res = {st_q.opnd[6:0], st_q.fl.c};
                `RCA_OP_SWAPF: res = {st_q.opnd[3:0], st_q.opnd[7:4]};
                default: res = st_q.opnd;
            endcase
            // a nop word must not touch anything
            if (op == `RCA_OP_MOVWF && !dest_f) begin
                upd_z = 1'b0;
            end
            if (op == `RCA_OP_MOVWF || op == `RCA_OP_RRF || op == `RCA_OP_RLF
                || op == `RCA_OP_SWAPF || op == `RCA_OP_DECFSZ || op == `RCA_OP_INCFSZ) begin
                upd_z = 1'b0;
            end
        end else if (grp == `RCA_GRP_LIT) begin
            case (op)
                `RCA_LOP_IOR: res = st_q.opnd | st_q.w;
                `RCA_LOP_AND: res = st_q.opnd & st_q.w;
                `RCA_LOP_XOR: res = st_q.opnd ^ st_q.w;
                4'hC, 4'hD, 4'hE, 4'hF: begin
                    res = {hi[3:0], lo[3:0]};
                    upd_c = 1'b1;
                end
                default: begin
                    res = st_q.opnd;
                    upd_z = 1'b0;
                end
            endcase
        end else begin
            upd_z = 1'b0;
        end
    end

    // ============================================================
    // phase sequencer and pipeline
    always_comb begin
        st_d = st_q;
        case (st_q.ph)
            rca_pkg::PH_ONE: st_d.ph = rca_pkg::PH_TWO;
            rca_pkg::PH_TWO: st_d.ph = rca_pkg::PH_THREE;
            rca_pkg::PH_THREE: st_d.ph = rca_pkg::PH_FOUR;
            rca_pkg::PH_FOUR: st_d.ph = rca_pkg::PH_ONE;
            default: st_d.ph = rca_pkg::PH_ONE;
        endcase
        // high for the second half of the cycle
        st_d.clkout = resistor_capacitor_osc_mode_i
            && (32'(st_d.ph) >= (`RCA_PHASES / 2));
        st_d.dbus.rd = 1'b0;
        st_d.dbus.wr = 1'b0;
        case (st_q.ph)
            rca_pkg::PH_ONE: begin
                st_d.take = 1'b0;
                st_d.skip = 1'b0;
                st_d.dbus.addr = ea;
                st_d.dbus.rd = (grp == `RCA_GRP_BYTE);
            end
            rca_pkg::PH_TWO: begin
                st_d.opnd = (grp == `RCA_GRP_BYTE) ? rd_val : st_q.ir[7:0];
            end
            rca_pkg::PH_THREE: begin
                if (upd_z) begin
                    st_d.fl.z = (res == 8'h00);
                end
                if (upd_c) begin
                    st_d.fl.c = hi[4];
                    st_d.fl.half_borrow_flag = lo[4];
                end
                if (grp == `RCA_GRP_BYTE && (op == `RCA_OP_RRF || op == `RCA_OP_RLF)) begin
                    st_d.fl.c = (op == `RCA_OP_RRF) ? st_q.opnd[0] : st_q.opnd[7];
                end
                if (grp == `RCA_GRP_BYTE && (op == `RCA_OP_DECFSZ || op == `RCA_OP_INCFSZ)) begin
                    st_d.skip = (res == 8'h00);
                end
                if (grp[1:1] == 1'b1 && st_q.ir[13:11] == `RCA_GOTO_PFX) begin
                    st_d.take = 1'b1;
                    st_d.tgt = {st_q.pc[12:11], st_q.ir[10:0]};
                end
                if (!wr_file) begin
                    if (grp == `RCA_GRP_LIT || (grp == `RCA_GRP_BYTE && upd_z)
                        || (grp == `RCA_GRP_BYTE && op != `RCA_OP_MOVWF)) begin
                        st_d.w = res;
                    end
                end else if (ea[6:0] == `RCA_SFR_PCL) begin
                    st_d.take = 1'b1;
                    st_d.tgt = {st_q.pc[12:8], res};
                end else if (ea[6:0] == `RCA_SFR_STATUS) begin
                    st_d.fl = res[2:0];
                end else if (ea[6:0] == `RCA_SFR_FSR) begin
                    st_d.fsr = res;
                end
                st_d.dbus.wr = wr_file && !sfr_hit;
                st_d.dbus.wdata = res;
            end
            rca_pkg::PH_FOUR: begin
                // a branch or skip flushes the word fetched meanwhile
                st_d.ir = (st_q.take || st_q.skip) ? `RCA_NOP : prog_data_i;
                st_d.pc = st_q.take ? st_q.tgt : st_q.pc + 13'h0001;
            end
            default: st_d.ph = rca_pkg::PH_ONE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign prog_addr_o = st_q.pc;
    assign data_req_o = st_q.dbus;
    assign flags_o = st_q.fl;
    assign instr_rate_output_o = st_q.clkout;

    // ============================================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence clk_hi2_s;
        instr_rate_output_o [*2];
    endsequence
    sequence clk_lo2_s;
        !instr_rate_output_o [*2];
    endsequence

    phase_wrap_a: assert property (st_q.ph == rca_pkg::PH_FOUR |=> st_q.ph == rca_pkg::PH_ONE)
        else $error("phase did not wrap after phase four");
    read_phase_a: assert property (data_req_o.rd |-> st_q.ph == rca_pkg::PH_TWO)
        else $error("data read outside phase two");
    write_phase_a: assert property (data_req_o.wr |-> st_q.ph == rca_pkg::PH_FOUR)
        else $error("data write outside phase four");
    fetch_latch_a: assert property (st_q.ph == rca_pkg::PH_FOUR && !st_q.take && !st_q.skip
        |=> st_q.ir == $past(prog_data_i) && prog_addr_o == $past(prog_addr_o) + 13'h0001)
        else $error("fetched word not latched or counter not advanced");
    branch_flush_a: assert property (st_q.ph == rca_pkg::PH_FOUR && st_q.take
        |=> st_q.ir == `RCA_NOP && prog_addr_o == $past(st_q.tgt))
        else $error("branch did not flush the pipeline");
    rate_clock_a: assert property ($rose(instr_rate_output_o) && resistor_capacitor_osc_mode_i
        |-> clk_hi2_s ##1 clk_lo2_s)
        else $error("output clock not at quarter rate");
    zero_flag_a: assert property (st_q.ph == rca_pkg::PH_THREE && upd_z && !(wr_file
        && ea[6:0] == `RCA_SFR_STATUS) |=> flags_o.z == ($past(res) == 8'h00))
        else $error("zero flag does not match result");
    sub_borrow_a: assert property (st_q.ph == rca_pkg::PH_THREE && is_sub && !(wr_file
        && ea[6:0] == `RCA_SFR_STATUS) |=> flags_o.c == ($past(st_q.opnd) >= $past(st_q.w)))
        else $error("carry is not the inverted borrow");
    add_carry_a: assert property (st_q.ph == rca_pkg::PH_THREE && upd_c && !is_sub && !(wr_file
        && ea[6:0] == `RCA_SFR_STATUS) |=> flags_o.c == ({1'b0, $past(st_q.opnd)}
        + {1'b0, $past(st_q.w)} > 9'h0FF))
        else $error("carry does not come from bit 7");
    reset_hold_a: assert property (disable iff (1'b0) !nrst_i |=> prog_addr_o == `RCA_RESET_VECTOR
        && !data_req_o.wr)
        else $error("core not held in reset");

endmodule

// ==== verification/rca_mem_model.sv ====
`timescale 1ns/10ps
module rca_mem_model (
    // clock
    input wire logic sys_clk_i,
    // program bus
    input wire logic [12:0] prog_addr_i,
    output logic [13:0] prog_data_o,
    // data bus
    input wire rca_pkg::rca_dbus_s data_req_i,
    output logic [7:0] data_rdata_o
);
    logic [13:0] rom [0:31];
    logic [7:0] ram [0:255];

    // ============================================================
    // program side
    // space beyond the loaded words reads as no-op
    assign prog_data_o = (prog_addr_i < 13'h0020) ? rom[prog_addr_i[4:0]] : 14'h0000;

    // ============================================================
    // data side
    // inverse outside phase two so a late sample never sees good data
    assign data_rdata_o = data_req_i.rd ? ram[data_req_i.addr] : ~ram[data_req_i.addr];
    always @(posedge sys_clk_i) begin
        if (data_req_i.wr) begin
            ram[data_req_i.addr] <= data_req_i.wdata;
        end
    end
endmodule

// ==== verification/risc_core_alu_datapath_tb.sv ====
`timescale 1ns/10ps
module risc_core_alu_datapath_tb;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rc_mode = 1'b0;
    logic [12:0] prog_addr;
    logic [13:0] prog_data;
    rca_pkg::rca_dbus_s data_req;
    logic [7:0] rdata;
    rca_pkg::rca_flags_s flags;
    logic clkout;
    int failures = 0;
    int comparisons = 0;

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    rca_core DUT (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .resistor_capacitor_osc_mode_i(rc_mode),
        .prog_addr_o(prog_addr),
        .prog_data_i(prog_data),
        .data_req_o(data_req),
        .data_rdata_i(rdata),
        .flags_o(flags),
        .instr_rate_output_o(clkout)
    );

    rca_mem_model mem (
        .sys_clk_i(sys_clk_i),
        .prog_addr_i(prog_addr),
        .prog_data_o(prog_data),
        .data_req_i(data_req),
        .data_rdata_o(rdata)
    );

    // ============================================================
    // compare and report
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input rca_pkg::rca_flags_s got, input rca_pkg::rca_flags_s exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ============================================================
    // program loading and running
    task automatic boot(input logic [13:0] prog [$]);
        for (int i = 0; i < 32; i++) begin
            mem.rom[i] = (i < prog.size()) ? prog[i] : 14'h0000;
        end
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
    endtask

    // n instruction cycles of four clocks each
    task automatic run(input int n);
        repeat (4 * n) @(posedge sys_clk_i);
        #1;
    endtask

    // ============================================================
    // scenarios
    task automatic t_add();
        boot('{14'h3088, 14'h00A0, 14'h07A0, 14'h3EF0, 14'h00A1});
        run(7);
        chk_val(mem.ram[8'h20], 16'h0010);
        chk_val(mem.ram[8'h21], 16'h0078);
        chk_flags(flags, 3'b001);
    endtask

    task automatic t_sub();
        boot('{14'h3001, 14'h3C01});
        run(4);
        chk_flags(flags, 3'b111);
        boot('{14'h3002, 14'h3C01, 14'h00A2});
        run(5);
        chk_val(mem.ram[8'h22], 16'h00FF);
        chk_flags(flags, 3'b000);
    endtask

    task automatic t_logic();
        boot('{14'h3081, 14'h00A4, 14'h0DA4, 14'h30F0, 14'h380F, 14'h393C, 14'h3A3C,
               14'h00A3});
        run(10);
        chk_val(mem.ram[8'h24], 16'h0002);
        chk_val(mem.ram[8'h23], 16'h0000);
        chk_flags(flags, 3'b101);
    endtask

    task automatic t_indirect();
        mem.ram[8'h04] = 8'hEE;
        boot('{14'h3030, 14'h0084, 14'h305A, 14'h0080, 14'h0A80});
        run(7);
        chk_val(mem.ram[8'h30], 16'h005B);
        chk_val(mem.ram[8'h04], 16'h00EE);
    endtask

    task automatic t_branch();
        logic seen3;
        seen3 = 1'b0;
        mem.ram[8'h26] = 8'h00;
        boot('{14'h3077, 14'h2804, 14'h00A6, 14'h0000, 14'h00A7});
        for (int i = 0; i < 32; i++) begin
            @(posedge sys_clk_i);
            #1;
            seen3 = seen3 | (prog_addr === 13'h0003);
        end
        chk_val(seen3, 16'h0000);
        chk_val(mem.ram[8'h26], 16'h0000);
        chk_val(mem.ram[8'h27], 16'h0077);
    endtask

    task automatic t_clock();
        logic [7:0] smp;
        logic [12:0] pc0;
        rc_mode <= 1'b1;
        boot('{14'h0000});
        run(2);
        pc0 = prog_addr;
        for (int i = 0; i < 8; i++) begin
            smp[i] = clkout;
            @(posedge sys_clk_i);
            #1;
        end
        // two low then two high, repeating every cycle
        for (int i = 2; i < 8; i++) begin
            chk_val(smp[i], {15'h0000, ~smp[i-2]});
        end
        chk_val(prog_addr, pc0 + 13'h0002);
        @(posedge sys_clk_i);
        rc_mode <= 1'b0;
        run(2);
        chk_val(clkout, 16'h0000);
    endtask

    task automatic t_reset();
        boot('{14'h3055, 14'h3EAB, 14'h2800});
        run(5);
        nrst_i <= 1'b0;
        run(1);
        chk_val(prog_addr, 16'h0000);
        chk_flags(flags, 3'b000);
        chk_val({data_req.rd, data_req.wr, clkout}, 16'h0000);
        nrst_i <= 1'b1;
    endtask

    // ============================================================
    // main sequence
    initial begin
        t_add();
        t_sub();
        t_logic();
        t_indirect();
        t_branch();
        t_clock();
        t_reset();
        results();
    end
endmodule
